/* File: common/asa_pkg.sv */
/*
  Constants and types of the alarm status aggregator: register offsets,
  field positions and reset values.
  Assumes a byte-wide register port with a 12-bit address.
*/
`default_nettype none

package asa_pkg;

  // Port and field widths
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ALM_W  = 5;
  localparam int unsigned RSVD_W = 3;

  typedef logic [ADDR_W-1:0] asa_addr_t;
  typedef logic [DATA_W-1:0] asa_data_t;
  typedef logic [ALM_W-1:0]  asa_alm_t;
  typedef logic [RSVD_W-1:0] asa_rsvd_t;

  // Register offsets
  localparam asa_addr_t OFF_SUMMARY = 12'h2c0;
  localparam asa_addr_t OFF_FLAGS   = 12'h2c1;
  localparam asa_addr_t OFF_MASKS   = 12'h2c2;
  localparam asa_addr_t OFF_PINSEL  = 12'h2c3;

  // Alarm positions, shared by flags and masks
  localparam int unsigned BIT_DIV     = 0;
  localparam int unsigned BIT_NCO     = 1;
  localparam int unsigned BIT_REALIGN = 2;
  localparam int unsigned BIT_LINK    = 3;
  localparam int unsigned BIT_PLL     = 4;

  // Single-bit fields
  localparam int unsigned SUMMARY_BIT = 0;
  localparam int unsigned PINSEL_BIT  = 0;

  // Reset values
  localparam asa_alm_t  RST_FLAGS  = 5'h1f;
  localparam asa_alm_t  RST_MASKS  = 5'h1f;
  localparam asa_rsvd_t RST_RSVD   = 3'h0;
  localparam asa_data_t RST_RDATA  = 8'h00;
  localparam logic      RST_PINSEL = 1'b0;

endpackage

`default_nettype wire

/* File: logic/asa_top.sv */
/*
  Alarm status aggregator: five sticky alarm flags, a mask per flag, a
  summary alarm bit, an interrupt level and a selectable status pin.
  Assumes one clock MCLK, reset NRST, a byte register port with read
  data one cycle after the read strobe, and event inputs that come from
  logic on MCLK, except PLL_LOCKED which may arrive from anywhere.
*/
// Implementation choice: the plain strobed port.
//
// Summary of operation
// - Summary reads one when unmasked flag set
// - Set mask drops flag from summary only
// - Unlocked PLL sets bit four flag
// - Enabled link outside data state sets bit three
// - Clock realignment event sets bit two
// - Link off, NCO sync, phase mismatch set bit one
// - Channel divider mismatch sets bit zero
// - Writing one clears flag, zero keeps it
// - Reset: flags, masks all ones, upper zero
// - Selected summary drives status output pin
`timescale 1ns/1ps
`default_nettype none

module asa_top (
  input  wire logic               MCLK,
  input  wire logic               NRST,
  input  wire asa_pkg::asa_addr_t ADDR,
  input  wire asa_pkg::asa_data_t WDATA,
  input  wire logic               WR,
  input  wire logic               RD,
  output var  asa_pkg::asa_data_t RDATA,
  input  wire logic               PLL_LOCKED,
  input  wire logic               LINK_ENABLE,
  input  wire logic               LINK_IN_DATA_STATE,
  input  wire logic               CLK_REALIGNED,
  input  wire logic               NCO_SYNCED,
  input  wire logic               PHASE_MISMATCH,
  input  wire logic               DIVIDER_MISMATCH,
  input  wire logic               CAL_STATUS,
  output var  logic               STATUS_PIN,
  output var  logic               IRQ
);
  import asa_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  asa_alm_t  flags_ff;
  asa_alm_t  nxt_flags;
  asa_alm_t  masks_ff;
  asa_rsvd_t flags_rsvd_ff;
  asa_rsvd_t masks_rsvd_ff;
  logic      pinsel_ff;
  asa_data_t rdata_ff;
  asa_data_t nxt_rdata;
  logic      pin_ff;
  logic      pll_meta_ff;
  logic      pll_s2_ff;
  logic      pll_s3_ff;
  logic      pll_lock_ff;
  asa_alm_t  set_vec;
  asa_alm_t  clr_vec;
  logic      alarm;

  // Register hit, used by every write and read path
  function automatic logic hit(input asa_addr_t a, input asa_addr_t off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // PLL lock synchroniser

  // Three stages; lock state moves only once stages two and three agree
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      pll_meta_ff <= 1'b0;
      pll_s2_ff   <= 1'b0;
      pll_s3_ff   <= 1'b0;
    end else begin
      pll_meta_ff <= PLL_LOCKED;
      pll_s2_ff   <= pll_meta_ff;
      pll_s3_ff   <= pll_s2_ff;
    end
  end

  // Filtered lock; starts unlocked so a fresh part reports lock loss
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      pll_lock_ff <= 1'b0;
    end else if (pll_s2_ff == pll_s3_ff) begin
      pll_lock_ff <= pll_s3_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarm set conditions

  // Levels set the flag on every cycle they hold, so clearing is futile
  // until the cause goes away
  always_comb begin
    set_vec              = '0;
    set_vec[BIT_PLL]     = !pll_lock_ff;
    set_vec[BIT_LINK]    = LINK_ENABLE && !LINK_IN_DATA_STATE;
    set_vec[BIT_REALIGN] = CLK_REALIGNED;
    set_vec[BIT_NCO]     = !LINK_ENABLE || NCO_SYNCED
                           || PHASE_MISMATCH;
    set_vec[BIT_DIV]     = DIVIDER_MISMATCH;
  end

  // Write-one clear mask for the flag register
  assign clr_vec = (WR && hit(ADDR, OFF_FLAGS)) ? WDATA[ALM_W-1:0] : '0;

  ////////////////////////////////////////////////////////////////////////
  // Sticky flags

  // One slice per flag; set is ORed last so it wins over a clear
  for (genvar i = 0; i < ALM_W; i++) begin : g_flag
    assign nxt_flags[i] = (flags_ff[i] && !clr_vec[i])
                          || set_vec[i];
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      flags_ff <= RST_FLAGS;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // Reserved upper bits are plain storage
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      flags_rsvd_ff <= RST_RSVD;
    end else if (WR && hit(ADDR, OFF_FLAGS)) begin
      flags_rsvd_ff <= WDATA[DATA_W-1:ALM_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mask and pin select registers

  // Masks start all set, so nothing interrupts until software opts in
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      masks_ff      <= RST_MASKS;
      masks_rsvd_ff <= RST_RSVD;
    end else if (WR && hit(ADDR, OFF_MASKS)) begin
      masks_ff      <= WDATA[ALM_W-1:0];
      masks_rsvd_ff <= WDATA[DATA_W-1:ALM_W];
    end
  end

  // Status pin source select
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      pinsel_ff <= RST_PINSEL;
    end else if (WR && hit(ADDR, OFF_PINSEL)) begin
      pinsel_ff <= WDATA[PINSEL_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Summary alarm and outputs

  // Masks gate only the summary; the flags keep their value
  assign alarm = |(flags_ff & ~masks_ff);
  assign IRQ   = alarm;

  // Registered pin; costs a cycle but keeps the pad glitch free
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      pin_ff <= 1'b0;
    end else begin
      pin_ff <= pinsel_ff ? alarm : CAL_STATUS;
    end
  end

  assign STATUS_PIN = pin_ff;

  ////////////////////////////////////////////////////////////////////////
  // Read port

  // Unmapped addresses read zero; reads have no side effects
  always_comb begin
    nxt_rdata = '0;
    if (hit(ADDR, OFF_SUMMARY)) begin
      nxt_rdata[SUMMARY_BIT] = alarm;
    end else if (hit(ADDR, OFF_FLAGS)) begin
      nxt_rdata = {flags_rsvd_ff, flags_ff};
    end else if (hit(ADDR, OFF_MASKS)) begin
      nxt_rdata = {masks_rsvd_ff, masks_ff};
    end else if (hit(ADDR, OFF_PINSEL)) begin
      nxt_rdata[PINSEL_BIT] = pinsel_ff;
    end
  end

  // Data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      rdata_ff <= RST_RDATA;
    end else begin
      rdata_ff <= RD ? nxt_rdata : RST_RDATA;
    end
  end

  assign RDATA = rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!NRST);

  summary_read_a : assert property (
    RD && hit(ADDR, OFF_SUMMARY)
    |=> RDATA[SUMMARY_BIT] == |($past(flags_ff) & ~$past(masks_ff)))
    else $error("summary read does not match flags and masks");

  mask_silence_a : assert property (
    masks_ff == RST_MASKS |-> !IRQ)
    else $error("fully masked alarms still raise the interrupt");

  mask_keeps_flag_a : assert property (
    WR && hit(ADDR, OFF_MASKS) && set_vec == '0
    |=> flags_ff == $past(flags_ff))
    else $error("mask write altered the flags");

  pll_flag_a : assert property (
    !pll_lock_ff |=> flags_ff[BIT_PLL])
    else $error("lock loss did not set its flag");

  pll_sync_a : assert property (
    $changed(pll_lock_ff) |-> $past(pll_s2_ff) == $past(pll_s3_ff))
    else $error("lock state moved before sync stages agreed");

  link_flag_a : assert property (
    LINK_ENABLE && !LINK_IN_DATA_STATE |=> flags_ff[BIT_LINK])
    else $error("link down did not set its flag");

  realign_flag_a : assert property (
    CLK_REALIGNED |=> flags_ff[BIT_REALIGN])
    else $error("realignment did not set its flag");

  nco_flag_a : assert property (
    !LINK_ENABLE || NCO_SYNCED || PHASE_MISMATCH |=> flags_ff[BIT_NCO])
    else $error("phase upset did not set its flag");

  div_flag_a : assert property (
    DIVIDER_MISMATCH |=> flags_ff[BIT_DIV])
    else $error("divider mismatch did not set its flag");

  w1c_clear_a : assert property (
    WR && hit(ADDR, OFF_FLAGS) && WDATA[BIT_DIV] && !set_vec[BIT_DIV]
    |=> !flags_ff[BIT_DIV])
    else $error("write one did not clear the flag");

  w0_keep_a : assert property (
    flags_ff[BIT_NCO] && !(WR && hit(ADDR, OFF_FLAGS) && WDATA[BIT_NCO])
    |=> flags_ff[BIT_NCO])
    else $error("flag dropped without a write one");

  set_wins_a : assert property (
    WR && hit(ADDR, OFF_FLAGS) && WDATA[BIT_DIV] && set_vec[BIT_DIV]
    |=> flags_ff[BIT_DIV])
    else $error("clear beat a simultaneous set");

  pin_route_a : assert property (
    pinsel_ff && alarm |=> STATUS_PIN)
    else $error("selected alarm not on the status pin");

endmodule

`default_nettype wire

/* File: sim/asa_tb.sv */
/*
  Self-checking bench of the alarm status aggregator.
  Assumes asa_pkg and asa_top are compiled before this file.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import asa_pkg::*;

  logic      mclk, nrst, wr, rd, pll, len, ldat, realn;
  logic      nsync, phase, divm, cal, spin, irq;
  asa_addr_t addr;
  asa_data_t wdata;
  asa_data_t rdata;
  int        num_errors;
  int        samples_checked;

  // Device under test, every input driven
  asa_top asa_top_i (
    .MCLK(mclk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .PLL_LOCKED(pll), .LINK_ENABLE(len), .LINK_IN_DATA_STATE(ldat),
    .CLK_REALIGNED(realn), .NCO_SYNCED(nsync), .PHASE_MISMATCH(phase),
    .DIVIDER_MISMATCH(divm), .CAL_STATUS(cal), .STATUS_PIN(spin), .IRQ(irq)
  );

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  //////////////////////////////////////////////////////////////////////////
  // Case equality so an unknown never passes
  task automatic chk(input asa_data_t got, input asa_data_t exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr_reg(input asa_addr_t a, input asa_data_t d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // Read data only stands in the cycle after the strobe
  task automatic rd_chk(input asa_addr_t a, input asa_data_t exp);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // Drive one alarm cause active or idle
  task automatic cause(input int k, input logic v);
    case (k)
      0: divm <= v;
      1: nsync <= v;
      2: realn <= v;
      3: ldat <= ~v;
      4: pll <= ~v;
      5: phase <= v;
      default: len <= ~v;
    endcase
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Reset values, then a wait for the lock filter before clearing
  task automatic do_reset;
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    #1;
    chk(asa_data_t'(irq), 8'h00);
    rd_chk(OFF_FLAGS, 8'h1f);
    rd_chk(OFF_MASKS, 8'h1f);
    rd_chk(OFF_SUMMARY, 8'h00);
    repeat (8) @(posedge mclk);
    wr_reg(OFF_FLAGS, 8'h1f);
    rd_chk(OFF_FLAGS, 8'h00);
    $display("test reset done");
  endtask

  // Each cause sets only its own flag; zero writes keep it
  task automatic test_events;
    for (int k = 0; k < 7; k++) begin
      int b;
      b = (k < 5) ? k : 1;
      @(posedge mclk);
      cause(k, 1'b1);
      repeat (4) @(posedge mclk);
      cause(k, 1'b0);
      repeat (10) @(posedge mclk);
      rd_chk(OFF_FLAGS, 8'h01 << b);
      wr_reg(OFF_FLAGS, ~(8'h01 << b) & 8'h1f);
      rd_chk(OFF_FLAGS, 8'h01 << b);
      wr_reg(OFF_FLAGS, 8'h01 << b);
      rd_chk(OFF_FLAGS, 8'h00);
    end
    $display("test events done");
  endtask

  // Mask gates summary and IRQ but leaves the flag; set beats clear
  task automatic test_mask;
    @(posedge mclk);
    divm <= 1'b1;
    @(posedge mclk);
    divm <= 1'b0;
    wr_reg(OFF_MASKS, 8'h1e);
    #1;
    chk(asa_data_t'(irq), 8'h01);
    rd_chk(OFF_SUMMARY, 8'h01);
    wr_reg(OFF_MASKS, 8'h01);
    #1;
    chk(asa_data_t'(irq), 8'h00);
    rd_chk(OFF_SUMMARY, 8'h00);
    rd_chk(OFF_FLAGS, 8'h01);
    // Cause only at the clear edge, so a lost set cannot be re-set later
    @(posedge mclk);
    divm <= 1'b1;
    wr <= 1'b1;
    addr <= OFF_FLAGS;
    wdata <= 8'h01;
    @(posedge mclk);
    divm <= 1'b0;
    wr <= 1'b0;
    rd_chk(OFF_FLAGS, 8'h01);
    @(posedge mclk);
    divm <= 1'b0;
    wr_reg(OFF_FLAGS, 8'h01);
    rd_chk(OFF_FLAGS, 8'h00);
    $display("test mask done");
  endtask

  // Pin source selection, reserved storage, unmapped and read-only places
  task automatic test_pin;
    wr_reg(OFF_PINSEL, 8'h00);
    cal <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(asa_data_t'(spin), 8'h01);
    wr_reg(OFF_MASKS, 8'h1e);
    wr_reg(OFF_PINSEL, 8'h01);
    repeat (2) @(posedge mclk);
    #1;
    chk(asa_data_t'(spin), 8'h00);
    @(posedge mclk);
    divm <= 1'b1;
    @(posedge mclk);
    divm <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(asa_data_t'(spin), 8'h01);
    wr_reg(OFF_FLAGS, 8'h01);
    cal <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(asa_data_t'(spin), 8'h00);
    wr_reg(OFF_MASKS, 8'he1);
    rd_chk(OFF_MASKS, 8'he1);
    wr_reg(12'h2c4, 8'hff);
    rd_chk(12'h2c4, 8'h00);
    wr_reg(OFF_SUMMARY, 8'hff);
    rd_chk(OFF_SUMMARY, 8'h00);
    $display("test pin done");
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence; second reset comes after the last test, just before the tally
  initial begin
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    pll = 1'b1;
    len = 1'b1;
    ldat = 1'b1;
    realn = 1'b0;
    nsync = 1'b0;
    phase = 1'b0;
    divm = 1'b0;
    cal = 1'b0;
    num_errors = 0;
    samples_checked = 0;
    do_reset;
    test_events;
    test_mask;
    test_pin;
    do_reset;
    tally_and_finish;
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    num_errors++;
    tally_and_finish;
  end
endmodule

`default_nettype wire
